// [dv/tb_repeater_port_event_counters.sv]
// Random self-checking bench for the repeater port event counters
`timescale 1ns/10ps
`default_nettype none
module tb_repeater_port_event_counters;
  import rpec_pkg::*;
  logic clk, rst, mb, car, col, anyc, jab, mism, inv, act, en;
  logic adm, rp, rt, rc;
  rpec_rate_t rate;
  logic [OCT_W-1:0] oct;
  logic [DUR_W-1:0] dur, slot;
  logic [3:0] pv;
  logic [ADDR_W-1:0] sa, e_addr, last;
  logic [CNT_W-1:0] c [7];
  logic [CNT_W-1:0] e [7];
  int n_errors, num_checks;

  rpec_top dut (.i_sys_clk(clk), .i_rst(rst), .i_rate(rate),
    .i_mismatch_method_b(mb), .i_slot_time_e(slot),
    .i_carrier_event_a(car), .i_collision_seen(col),
    .i_any_port_collision(anyc), .i_jabber_lockup_timer(jab),
    .i_received_octet_count(oct), .i_rate_mismatch(mism),
    .i_invalid_symbol(inv), .i_rx_jabber_entry(pv[0]),
    .i_partition_wait_entry(pv[1]), .i_state_d_from_false_carrier(pv[2]),
    .i_readable_frame(pv[3]), .i_source_address(sa),
    .i_port_admin_action(act), .i_port_admin_enable(en),
    .o_port_admin_state(adm), .o_restart_partition(rp),
    .o_restart_rx_timer(rt), .o_restart_carrier_integrity(rc),
    .o_activity_duration_b(dur), .o_very_long_event_count(c[0]),
    .o_rate_mismatch_count(c[1]), .o_auto_partition_count(c[2]),
    .o_auto_isolation_count(c[3]), .o_in_packet_symbol_error_count(c[4]),
    .o_address_change_count(c[5]), .o_gigabit_burst_count(c[6]),
    .o_last_source_address(last));

  always #12.5 clk = ~clk;

  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic check_all();
    @(negedge clk);
    check("very long", c[0], e[0]);
    check("mismatch", c[1], e[1]);
    check("partition", c[2], e[2]);
    check("isolation", c[3], e[3]);
    check("symbol error", c[4], e[4]);
    check("address change", c[5], e[5]);
    check("burst", c[6], e[6]);
    check("last address", last, e_addr);
  endtask

  // Returns {very long, mismatch, symbol error, burst} increments
  function automatic logic [3:0] incs(rpec_rate_t r, int d, logic cl,
      logic ac, logic jb, int oc, logic mm, logic iv, logic b);
    logic lng;
    // Gigabit events stay short, so only octets make them valid length
    lng = (r == RPEC_RATE_10) ? d > VPMIN_CYC_10 :
      (r == RPEC_RATE_100) ? d > VPMIN_CYC_100 : 1'b0;
    incs[3] = r == RPEC_RATE_10 && jb;
    incs[2] = (r == RPEC_RATE_1000) ? mm : !cl && mm && (b ? oc > 63 : lng);
    incs[1] = iv && !ac && (lng || oc > 63);
    incs[0] = r == RPEC_RATE_1000 && !cl && d >= 64;
  endfunction

  task automatic ev(rpec_rate_t r, int len, logic cl, logic ac, logic jb,
      int oc, logic mm, logic iv, logic b);
    logic [3:0] x;
    x = incs(r, len, cl, ac | cl, jb, oc, mm, iv, b);
    @(posedge clk);
    rate <= r;
    mb <= b;
    car <= 1'b1;
    col <= cl;
    anyc <= ac | cl;
    jab <= jb;
    oct <= OCT_W'(oc);
    mism <= mm;
    inv <= iv;
    repeat (len) @(posedge clk);
    car <= 1'b0;
    repeat (5) @(posedge clk);
    {col, anyc, jab, mism, inv} <= 5'h00;
    e[0] += CNT_W'(x[3]);
    e[1] += CNT_W'(x[2]);
    e[4] += CNT_W'(x[1]);
    e[6] += CNT_W'(x[0]);
    check_all();
    check("duration", dur, 64'(len));
  endtask

  task automatic pulse(int k);
    @(posedge clk);
    pv[k] <= 1'b1;
    @(posedge clk);
    pv[k] <= 1'b0;
  endtask

  task automatic frame(logic [ADDR_W-1:0] a);
    @(posedge clk);
    sa <= a;
    pv[3] <= 1'b1;
    @(posedge clk);
    pv[3] <= 1'b0;
    if (a !== e_addr) e[5]++;
    e_addr = a;
    repeat (2) @(posedge clk);
    check_all();
  endtask

  task automatic admin(logic v);
    @(posedge clk);
    act <= 1'b1;
    en <= v;
    @(posedge clk);
    act <= 1'b0;
    @(negedge clk);
    check("admin state", adm, v);
    check("restart partition", rp, v);
    check("restart timer", rt, v && rate == RPEC_RATE_1000);
    check("restart integrity", rc, v && rate == RPEC_RATE_1000);
    @(negedge clk);
    check("restart pulse", {rp, rt, rc}, 3'b000);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    // Long enough for the slowest seed, well short of the cycle budget
    #2000000;
    n_errors++;
    conclude();
  end

  initial begin
    rpec_rate_t r;
    int len;
    int oc;
    clk = 1'b0;
    rst = 1'b1;
    {mb, car, col, anyc, jab, mism, inv, act, en} = 9'h000;
    rate = RPEC_RATE_10;
    oct = 16'h0000;
    slot = 16'h0040;
    pv = 4'h0;
    sa = 48'h0000_0000_0000;
    e_addr = ADDR_RST;
    for (int k = 0; k < 7; k++) e[k] = CNT_RST;
    void'($urandom(56));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    check_all();
    check("admin reset", adm, 1'b1);
    frame(48'h0000_0000_0000);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      rate <= rpec_rate_t'(k);
      admin(1'b0);
      pulse(2);
      e[3]++;
      admin(1'b1);
      pulse(1);
      e[2]++;
      // Jabber-state entries only count above 10 Mb/s
      if (k != 0) begin
        pulse(0);
        e[0]++;
      end
      check_all();
    end
    admin(1'b0);
    pulse(2);
    e[3]++;
    check_all();
    check("admin after isolate", adm, 1'b0);
    admin(1'b1);
    ev(RPEC_RATE_10, 2300, 1'b1, 1'b0, 1'b1, 64, 1'b1, 1'b1, 1'b0);
    ev(RPEC_RATE_1000, 100, 1'b0, 1'b1, 1'b0, 64, 1'b0, 1'b1, 1'b0);
    ev(RPEC_RATE_100, 260, 1'b0, 1'b0, 1'b0, 10, 1'b1, 1'b1, 1'b0);
    ev(RPEC_RATE_100, 260, 1'b0, 1'b0, 1'b0, 10, 1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 40; i++) begin
      r = rpec_rate_t'($urandom % 3);
      len = 4 + $urandom % 196;
      if (r == RPEC_RATE_10 && $urandom % 4 == 0) len = 2300;
      if (r == RPEC_RATE_100 && $urandom % 3 == 0) len = 260;
      // Keep clear of the slot time so rounding cannot decide a burst
      if (len inside {[60:68]}) len = 80;
      oc = ($urandom % 2) ? 63 + $urandom % 2 : $urandom % 200;
      ev(r, len, $urandom % 4 == 0, $urandom % 4 == 0, $urandom % 2, oc,
        $urandom % 2, $urandom % 2, $urandom % 2);
      if ($urandom % 2) frame(($urandom % 3 == 0) ? e_addr :
        {16'($urandom), 32'($urandom)});
    end
    conclude();
  end
endmodule
`default_nettype wire

// [src/rpec_addr_track.sv]
// Last source address store with change detection
`timescale 1ns/10ps
`default_nettype none
module rpec_addr_track
  import rpec_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Readable frame source address
  input wire logic i_sa_valid,
  input wire logic [ADDR_W-1:0] i_sa,
  // Stored address and change pulse
  output logic [ADDR_W-1:0] o_last_source_address,
  output logic o_changed
);
  logic [ADDR_W-1:0] addr_ff;
  logic changed_ff;
  wire differs = i_sa_valid && (i_sa != addr_ff);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      addr_ff <= ADDR_RST;
      changed_ff <= 1'b0;
    end else begin
      changed_ff <= differs;
      if (i_sa_valid) begin
        addr_ff <= i_sa;
      end
    end
  end
  assign o_last_source_address = addr_ff;
  assign o_changed = changed_ff;

  addr_update_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_sa_valid |=> o_last_source_address == $past(i_sa))
    else $error("last source address not updated");
  addr_change_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    o_changed == (!$past(i_rst) && $past(o_last_source_address)
                  != o_last_source_address))
    else $error("change pulse does not match address change");
endmodule
`default_nettype wire

// [src/rpec_counter.sv]
// Non-resettable-by-management wrapping event counter
`timescale 1ns/10ps
`default_nettype none
module rpec_counter
  import rpec_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Event
  input wire logic i_inc,
  // Count
  output logic [CNT_W-1:0] o_count
);
  logic [CNT_W-1:0] count_ff;
  wire [CNT_W-1:0] nxt_count = count_ff + CNT_W'(1);

  // Only the device reset clears it; it counts up and wraps
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      count_ff <= CNT_RST;
    end else if (i_inc) begin
      count_ff <= nxt_count;
    end
  end
  assign o_count = count_ff;

  count_wraps_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_inc |=> o_count == $past(o_count) + CNT_W'(1))
    else $error("counter did not step by one");
  count_holds_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !i_inc |=> $stable(o_count))
    else $error("counter changed without an event");
endmodule
`default_nettype wire

// [src/rpec_pkg.sv]
// Package of constants and types for the repeater port event counters
package rpec_pkg;
  localparam int CNT_W = 32;
  localparam int ADDR_W = 48;
  localparam int DUR_W = 16;
  localparam int OCT_W = 16;
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 48'h0000_0000_0000;
  localparam logic [DUR_W-1:0] DUR_RST = 16'h0000;
  // Bit time at 10 and 100 Mb/s, in picoseconds
  localparam int BT_PS_10 = 100000;
  localparam int BT_PS_100 = 10000;
  localparam int CLK_PS = 25000;
  // Valid-packet minimum time, bit times (552 <= t < 565)
  localparam int VPMIN_BT = 552;
  // Octets above which method B counts a mismatch
  localparam logic [OCT_W-1:0] MISMATCH_OCT_MIN = 16'h003F;
  // Activity duration thresholds are given in system clock cycles
  localparam logic [DUR_W-1:0] VPMIN_CYC_10 =
    DUR_W'((VPMIN_BT * BT_PS_10 + CLK_PS - 1) / CLK_PS);
  localparam logic [DUR_W-1:0] VPMIN_CYC_100 =
    DUR_W'((VPMIN_BT * BT_PS_100 + CLK_PS - 1) / CLK_PS);
  // Port rate encoding
  typedef enum logic [1:0] {
    RPEC_RATE_10 = 2'b00,
    RPEC_RATE_100 = 2'b01,
    RPEC_RATE_1000 = 2'b10
  } rpec_rate_t;
  // Carrier event tracking states
  typedef enum logic [1:0] {
    RPEC_IDLE = 2'b00,
    RPEC_ACTIVE = 2'b01,
    RPEC_CLOSE = 2'b10
  } rpec_state_t;
endpackage

// [src/rpec_top.sv]
// Per-port repeater event counters and administrative control
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - 10M: count carrier events longer than the jabber lockup timer.
// - 100M/1G: count each entry to the receive jabber state.
// - A very long event may also bump other counters.
// - Rate mismatch counts per frame using one fixed method.
// - Method A: no collision, duration over minimum, rate mismatch (10/100).
// - Method B: no collision, over 63 octets, rate mismatch (10/100).
// - Method C at 1000M: rate mismatch alone counts.
// - Mismatch threshold is the implementer's; other counters unaffected.
// - Count each automatic partition (entry to partition wait).
// - Count each false-carrier to state_d transition.
// - Automatic isolation leaves administrative state unchanged.
// - Symbol error counts at most once per valid-length event.
// - No symbol error count when any repeater port collides.
// - Hold source address of latest readable frame.
// - Count each change of the stored source address.
// - 1000M: count no-collision events lasting at least one slot time.
// - Burst counter never moves at 10 or 100M.
// - Enabling port at 10/100M restarts partition machine.
// - Enabling port at 1G restarts receive timer, partition, integrity.
// - Counters cannot be cleared by management and only count up.
// - Valid-packet minimum time between 552 and 565 bit times; at 1000M the code uses the 100M value of 221 cycles.
module rpec_top
  import rpec_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Port configuration
  input wire rpec_pkg::rpec_rate_t i_rate,
  input wire logic i_mismatch_method_b,
  input wire logic [rpec_pkg::DUR_W-1:0] i_slot_time_e,
  // Carrier and collision observation
  input wire logic i_carrier_event_a,
  input wire logic i_collision_seen,
  input wire logic i_any_port_collision,
  input wire logic i_jabber_lockup_timer,
  input wire logic [rpec_pkg::OCT_W-1:0] i_received_octet_count,
  input wire logic i_rate_mismatch,
  input wire logic i_invalid_symbol,
  // State machine events
  input wire logic i_rx_jabber_entry,
  input wire logic i_partition_wait_entry,
  input wire logic i_state_d_from_false_carrier,
  // Readable frame source address
  input wire logic i_readable_frame,
  input wire logic [rpec_pkg::ADDR_W-1:0] i_source_address,
  // Administrative control
  input wire logic i_port_admin_action,
  input wire logic i_port_admin_enable,
  output logic o_port_admin_state,
  output logic o_restart_partition,
  output logic o_restart_rx_timer,
  output logic o_restart_carrier_integrity,
  // Activity duration, cycles of the current or most recent event
  output logic [rpec_pkg::DUR_W-1:0] o_activity_duration_b,
  // Counters and last source address
  output logic [rpec_pkg::CNT_W-1:0] o_very_long_event_count,
  output logic [rpec_pkg::CNT_W-1:0] o_rate_mismatch_count,
  output logic [rpec_pkg::CNT_W-1:0] o_auto_partition_count,
  output logic [rpec_pkg::CNT_W-1:0] o_auto_isolation_count,
  output logic [rpec_pkg::CNT_W-1:0] o_in_packet_symbol_error_count,
  output logic [rpec_pkg::CNT_W-1:0] o_address_change_count,
  output logic [rpec_pkg::CNT_W-1:0] o_gigabit_burst_count,
  output logic [rpec_pkg::ADDR_W-1:0] o_last_source_address
);
  import rpec_pkg::*;

  function automatic logic [DUR_W-1:0] sat_inc(input logic [DUR_W-1:0] v);
    sat_inc = (v == {DUR_W{1'b1}}) ? v : v + DUR_W'(1);
  endfunction

  // Event tracking and administrative state
  rpec_state_t state_ff;
  rpec_state_t nxt_state;
  logic [DUR_W-1:0] dur_ff;
  logic coll_ff;
  logic any_coll_ff;
  logic jab_ff;
  logic mism_ff;
  logic symerr_ff;
  logic [OCT_W-1:0] oct_ff;
  logic admin_ff;
  logic restart_ff;
  logic [DUR_W-1:0] nxt_dur;

  wire is_gig = (i_rate == RPEC_RATE_1000);
  wire is_10 = (i_rate == RPEC_RATE_10);
  wire in_event = (state_ff == RPEC_ACTIVE);
  wire ev_close = (state_ff == RPEC_CLOSE);
  // Duration saturates so a very long event never looks short
  assign nxt_dur = sat_inc(dur_ff);

  // Valid-packet minimum time: the 10M value at 10M, the 100M value at 100M and 1000M
  wire [DUR_W-1:0] vpmin_cyc = is_10 ? VPMIN_CYC_10 : VPMIN_CYC_100;
  wire long_enough = dur_ff > vpmin_cyc;
  wire valid_len = long_enough
    || (oct_ff > MISMATCH_OCT_MIN);

  always_comb begin
    case (state_ff)
      RPEC_IDLE: begin
        nxt_state = i_carrier_event_a ? RPEC_ACTIVE : RPEC_IDLE;
      end
      RPEC_ACTIVE: begin
        nxt_state = i_carrier_event_a ? RPEC_ACTIVE : RPEC_CLOSE;
      end
      RPEC_CLOSE: begin
        nxt_state = i_carrier_event_a ? RPEC_ACTIVE : RPEC_IDLE;
      end
      default: begin
        nxt_state = RPEC_IDLE;
      end
    endcase
  end

  wire ev_start = i_carrier_event_a && (state_ff != RPEC_ACTIVE);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_ff <= RPEC_IDLE;
      dur_ff <= DUR_RST;
      coll_ff <= 1'b0;
      any_coll_ff <= 1'b0;
      jab_ff <= 1'b0;
      mism_ff <= 1'b0;
      symerr_ff <= 1'b0;
      oct_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (ev_start) begin
        dur_ff <= DUR_W'(1);
        coll_ff <= i_collision_seen;
        any_coll_ff <= i_any_port_collision;
        jab_ff <= i_jabber_lockup_timer;
        mism_ff <= i_rate_mismatch;
        symerr_ff <= i_invalid_symbol;
        oct_ff <= i_received_octet_count;
      end else if (in_event && i_carrier_event_a) begin
        dur_ff <= nxt_dur;
        coll_ff <= coll_ff | i_collision_seen;
        any_coll_ff <= any_coll_ff | i_any_port_collision;
        jab_ff <= jab_ff | i_jabber_lockup_timer;
        mism_ff <= mism_ff | i_rate_mismatch;
        symerr_ff <= symerr_ff | i_invalid_symbol;
        oct_ff <= i_received_octet_count;
      end
    end
  end
  assign o_activity_duration_b = dur_ff;

  // Counter increment terms; mismatch, symbol error, burst and 10M very long are evaluated at the close of each event
  wire inc_very_long = is_10 ? (ev_close && jab_ff)
                             : i_rx_jabber_entry;
  // Method chosen by strap: A by duration, B by octets; C at gigabit
  wire mism_a = !coll_ff && long_enough && mism_ff;
  wire mism_b = !coll_ff && (oct_ff > MISMATCH_OCT_MIN) && mism_ff;
  wire mism_c = mism_ff;
  wire inc_mismatch = ev_close && (is_gig ? mism_c
    : (i_mismatch_method_b ? mism_b : mism_a));
  wire inc_partition = i_partition_wait_entry;
  wire inc_isolation = i_state_d_from_false_carrier;
  wire inc_symerr = ev_close && valid_len && symerr_ff
    && !any_coll_ff && !coll_ff;
  wire inc_burst = ev_close && is_gig && !coll_ff
    && (dur_ff >= i_slot_time_e);
  wire addr_changed;

  // Each counter sees only its own term; coincident events all count
  rpec_counter u_cnt_vle (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_inc(inc_very_long),
    .o_count(o_very_long_event_count));
  rpec_counter u_cnt_mism (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_inc(inc_mismatch),
    .o_count(o_rate_mismatch_count));
  rpec_counter u_cnt_part (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_inc(inc_partition),
    .o_count(o_auto_partition_count));
  rpec_counter u_cnt_iso (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_inc(inc_isolation),
    .o_count(o_auto_isolation_count));
  rpec_counter u_cnt_sym (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_inc(inc_symerr),
    .o_count(o_in_packet_symbol_error_count));
  rpec_counter u_cnt_addr (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_inc(addr_changed),
    .o_count(o_address_change_count));
  rpec_counter u_cnt_burst (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_inc(inc_burst),
    .o_count(o_gigabit_burst_count));

  rpec_addr_track u_addr (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_sa_valid(i_readable_frame),
    .i_sa(i_source_address),
    .o_last_source_address(o_last_source_address),
    .o_changed(addr_changed));

  // Administrative state changes only by management action
  wire enable_edge = i_port_admin_action && i_port_admin_enable;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      admin_ff <= 1'b1;
      restart_ff <= 1'b0;
    end else begin
      if (i_port_admin_action) begin
        admin_ff <= i_port_admin_enable;
      end
      restart_ff <= enable_edge;
    end
  end
  assign o_port_admin_state = admin_ff;
  assign o_restart_partition = restart_ff;
  assign o_restart_rx_timer = restart_ff && is_gig;
  assign o_restart_carrier_integrity = restart_ff && is_gig;

  // Each count is checked one edge after the term that should move it
  burst_slow_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !is_gig |=> $stable(o_gigabit_burst_count))
    else $error("burst counted below gigabit");
  burst_count_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (ev_close && is_gig && !coll_ff && dur_ff >= i_slot_time_e)
    |=> o_gigabit_burst_count == $past(o_gigabit_burst_count) + 1)
    else $error("gigabit burst not counted");
  burst_coll_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (ev_close && coll_ff) |=> $stable(o_gigabit_burst_count))
    else $error("burst counted with collision");
  burst_short_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (ev_close && dur_ff < i_slot_time_e)
    |=> $stable(o_gigabit_burst_count))
    else $error("burst counted below slot time");
  burst_idle_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !ev_close |=> $stable(o_gigabit_burst_count))
    else $error("burst counted outside event close");
  symerr_coll_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (ev_close && any_coll_ff) |=> $stable(o_in_packet_symbol_error_count))
    else $error("symbol error counted during collision");
  symerr_once_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !ev_close |=> $stable(o_in_packet_symbol_error_count))
    else $error("symbol error counted outside event close");
  symerr_count_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (ev_close && symerr_ff && valid_len && !coll_ff && !any_coll_ff)
    |=> o_in_packet_symbol_error_count
      == $past(o_in_packet_symbol_error_count) + 32'h0000_0001)
    else $error("symbol error not counted");
  symerr_clean_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (ev_close && !symerr_ff) |=> $stable(o_in_packet_symbol_error_count))
    else $error("symbol error counted without bad symbol");
  symerr_short_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (ev_close && !valid_len) |=> $stable(o_in_packet_symbol_error_count))
    else $error("symbol error counted on short event");
  isolate_admin_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !i_port_admin_action |=> $stable(o_port_admin_state))
    else $error("admin state changed without management action");
  admin_take_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_port_admin_action |=> o_port_admin_state == $past(i_port_admin_enable))
    else $error("admin state did not follow management action");
  part_count_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_partition_wait_entry
    |=> o_auto_partition_count == $past(o_auto_partition_count) + 1)
    else $error("partition not counted");
  part_hold_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !i_partition_wait_entry |=> $stable(o_auto_partition_count))
    else $error("partition count moved without entry");
  iso_count_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_state_d_from_false_carrier
    |=> o_auto_isolation_count == $past(o_auto_isolation_count) + 1)
    else $error("isolation not counted");
  iso_hold_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !i_state_d_from_false_carrier |=> $stable(o_auto_isolation_count))
    else $error("isolation count moved without transition");
  restart_gig_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (enable_edge && is_gig) |=> o_restart_rx_timer && o_restart_partition
      && o_restart_carrier_integrity)
    else $error("gigabit enable did not restart machines");
  restart_slow_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (enable_edge && !is_gig) |=> o_restart_partition
      && !o_restart_rx_timer && !o_restart_carrier_integrity)
    else $error("slow enable restart outputs wrong");
  restart_once_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !enable_edge |=> !o_restart_partition && !o_restart_rx_timer)
    else $error("restart pulse without enabling action");
  mism_coll_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (ev_close && !is_gig && coll_ff) |=> $stable(o_rate_mismatch_count))
    else $error("mismatch counted with collision");
  mism_gig_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (ev_close && is_gig && mism_ff)
    |=> o_rate_mismatch_count == $past(o_rate_mismatch_count) + 1)
    else $error("gigabit mismatch not counted");
  mism_dur_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (ev_close && !is_gig && !i_mismatch_method_b && !coll_ff && mism_ff
      && dur_ff > vpmin_cyc)
    |=> o_rate_mismatch_count == $past(o_rate_mismatch_count) + 1)
    else $error("duration method mismatch not counted");
  mism_oct_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (ev_close && !is_gig && i_mismatch_method_b && !coll_ff && mism_ff
      && oct_ff > MISMATCH_OCT_MIN)
    |=> o_rate_mismatch_count == $past(o_rate_mismatch_count) + 1)
    else $error("octet method mismatch not counted");
  mism_once_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !(ev_close && mism_ff) |=> $stable(o_rate_mismatch_count))
    else $error("mismatch counted without detected mismatch");
  vle_jab_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (!is_10 && i_rx_jabber_entry)
    |=> o_very_long_event_count == $past(o_very_long_event_count) + 1)
    else $error("jabber entry not counted");
  vle_ten_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (is_10 && ev_close && jab_ff)
    |=> o_very_long_event_count == $past(o_very_long_event_count) + 1)
    else $error("very long event not counted");
  vle_hold_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (is_10 ? !(ev_close && jab_ff) : !i_rx_jabber_entry)
    |=> $stable(o_very_long_event_count))
    else $error("very long count moved without cause");
  dur_start_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    ev_start |=> o_activity_duration_b == 16'h0001)
    else $error("duration did not restart at carrier");
  dur_grow_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (in_event && i_carrier_event_a && dur_ff != 16'hFFFF)
    |=> o_activity_duration_b == $past(o_activity_duration_b) + 16'h0001)
    else $error("duration did not advance");
endmodule
`default_nettype wire
